// ==== alu_consts.svh ====
// constants for the rotate/subtract/skip datapath
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
`define ACC_RESET 8'h00
`define MEM_ALL_ONES 8'hff
`define FLAGS_RESET 6'h00
`define SKIP_CYCLES 2'h2
`define FLG_TWOS_RANGE 0
`define FLG_Z 1
`define FLG_AUX_CARRY 2
`define FLG_C 3
`define FLG_SIGNED_CARRY 4
`define FLG_CHAINED_ZERO 5
`endif

// ==== alu_pkg.sv ====
// types shared by the rotate/subtract/skip datapath
package alu_pkg;
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_ROT_LEFT_TO_ACC = 5'h01,
    OP_ROT_LEFT_CARRY_MEM = 5'h02,
    OP_ROT_LEFT_CARRY_TO_ACC = 5'h03,
    OP_ROT_RIGHT_MEM = 5'h04,
    OP_ROT_RIGHT_TO_ACC = 5'h05,
    OP_ROT_RIGHT_CY_MEM = 5'h06,
    OP_ROT_RIGHT_CY_TO_ACC = 5'h07,
    OP_SUB_BORROW_ACC = 5'h08,
    OP_SUB_BORROW_ACC_IMM = 5'h09,
    OP_SUB_BORROW_MEM = 5'h0a,
    OP_MINUS_ACC = 5'h0b,
    OP_MINUS_ACC_IMM = 5'h0c,
    OP_MINUS_MEM = 5'h0d,
    OP_DEC_SKIP_MEM = 5'h0e,
    OP_DEC_SKIP_ACC = 5'h0f,
    OP_INC_SKIP_MEM = 5'h10,
    OP_INC_SKIP_ACC = 5'h11,
    OP_SKIP_NZ_BYTE = 5'h12,
    OP_SKIP_NZ_BIT = 5'h13,
    OP_SET_BYTE = 5'h14,
    OP_SET_BIT = 5'h15,
    OP_SWAP_MEM = 5'h16
  } alu_op_e;

  typedef struct packed {
    alu_op_e op;
    logic [7:0] mem;
    logic [7:0] literal;
    logic [2:0] bit_sel;
  } alu_req_s;

  // bit order follows the flag positions in the constants header
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_carry;
    logic carry;
    logic auxiliary_carry;
    logic zero;
    logic twos_complement_range_flag;
  } alu_flags_s;

  typedef enum logic [0:0] {
    SEQ_RUN = 1'b0,
    SEQ_DUMMY = 1'b1
  } seq_state_e;
endpackage

// ==== alu_subtractor.sv ====
// 8-bit subtractor with borrow-in and arithmetic status outputs
`timescale 1ns/100ps
module alu_subtractor (
  input wire logic [7:0] i_a, // minuend
  input wire logic [7:0] i_b, // subtrahend
  input wire logic i_carry_in, // carry in, borrow is its inverse
  output logic [7:0] o_diff, // a - b - ~carry, modulo 256
  output logic o_carry, // 1 when no borrow out
  output logic o_aux, // 1 when no borrow out of the low nibble
  output logic o_ovf // signed overflow
);
  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    // a + ~b + c is the two's complement form of a - b - ~c
    full = {1'b0, i_a} + {1'b0, ~i_b} + {8'h00, i_carry_in};
    low = {1'b0, i_a[3:0]} + {1'b0, ~i_b[3:0]} + {4'h0, i_carry_in};
    o_diff = full[7:0];
    o_carry = full[8];
    o_aux = low[4];
    o_ovf = (i_a[7] != i_b[7]) && (full[7] != i_a[7]);
  end
endmodule

// ==== alu_datapath.sv ====
// rotate, subtract, set, swap and skip datapath for an 8-bit core
// Function
// RULE_01 - rotate left to acc: bit 7 to bit 0, memory and flags unchanged
// RULE_02 - rotate left through carry into memory, old bit 7 into carry
// RULE_03 - rotate left through carry into acc, carry from bit 7
// RULE_04 - rotate right into memory, bit 0 to bit 7, no flags
// RULE_05 - rotate right into acc, memory and all flags unchanged
// RULE_06 - rotate right through carry into memory, old bit 0 into carry
// RULE_07 - rotate right through carry into acc, carry from bit 0
// RULE_08 - acc minus memory minus inverted carry into acc, six flags updated
// RULE_09 - acc minus literal minus inverted carry into acc, six flags updated
// RULE_10 - acc minus memory minus inverted carry into memory, flags updated
// RULE_11 - subtract clears carry on negative result, sets it otherwise
// RULE_12 - acc minus memory, no borrow in, into acc, flags updated
// RULE_13 - acc minus memory, no borrow in, into memory, flags updated
// RULE_14 - acc minus literal, no borrow in, into acc, flags updated
// RULE_15 - decrement memory, write back, skip next when zero, no flags
// RULE_16 - memory minus one into acc, skip when zero, memory unchanged
// RULE_17 - increment memory, write back, skip next when zero, no flags
// RULE_18 - memory plus one into acc, skip when zero, memory unchanged
// RULE_19 - skip next when byte or selected bit is non-zero, no flags
// RULE_20 - every skip takes two instruction cycles via a dummy slot
// RULE_21 - set writes ff to byte or one to selected bit, no flags
// RULE_22 - swap nibbles of memory byte in place, flags unchanged
// RULE_23 - a skipped instruction is discarded and has no effect
// RULE_24 - zero flag tracks result byte; all values wrap modulo 256
`timescale 1ns/100ps
`include "alu_consts.svh"
module alu_datapath (
  input wire logic i_sys_clk, // 10 mhz core clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_req_valid, // one instruction issued this cycle
  input wire alu_pkg::alu_req_s i_req, // opcode and operands
  output logic [7:0] o_acc, // accumulator
  output alu_pkg::alu_flags_s o_flags, // status flags
  output logic o_mem_we, // memory write strobe, one cycle
  output logic [7:0] o_mem_wdata, // memory write data
  output logic o_skip, // skip taken, one cycle pulse
  output logic o_busy, // dummy cycle in progress, issue discarded
  output logic o_done // instruction retired, one cycle pulse
);
  import alu_pkg::*;

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rstn;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rstn = rst_sync2_reg;

  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  logic [7:0] sub_b;
  logic sub_cin;
  logic [7:0] sub_diff;
  logic sub_cy;
  logic sub_aux;
  logic sub_range;

  alu_subtractor alu_subtractor_i (
    .i_a(o_acc),
    .i_b(sub_b),
    .i_carry_in(sub_cin),
    .o_diff(sub_diff),
    .o_carry(sub_cy),
    .o_aux(sub_aux),
    .o_ovf(sub_range)
  );

  logic [7:0] acc_reg, acc_next;
  alu_flags_s flags_reg, flags_next;
  logic mem_we_reg, mem_we_next;
  logic [7:0] mem_wdata_reg, mem_wdata_next;
  logic skip_reg, skip_next;
  logic done_reg, done_next;
  seq_state_e state_reg, state_next;
  logic issue;
  logic [7:0] dec_val;
  logic [7:0] inc_val;
  logic is_imm;
  logic use_borrow;

  // an issue during the dummy slot is the discarded instruction
  assign issue = i_req_valid && (state_reg == SEQ_RUN); // see RULE_23
  assign dec_val = i_req.mem - 8'h01; // see RULE_24
  assign inc_val = i_req.mem + 8'h01; // see RULE_24
  assign is_imm = (i_req.op == OP_SUB_BORROW_ACC_IMM) || (i_req.op == OP_MINUS_ACC_IMM);
  assign use_borrow = (i_req.op == OP_SUB_BORROW_ACC) || (i_req.op == OP_SUB_BORROW_ACC_IMM) ||
    (i_req.op == OP_SUB_BORROW_MEM);
  assign sub_b = is_imm ? i_req.literal : i_req.mem; // see RULE_09
  // plain subtract behaves as borrow-with-carry-set
  assign sub_cin = use_borrow ? flags_reg.carry : 1'b1; // see RULE_12

  always_comb begin
    acc_next = acc_reg;
    flags_next = flags_reg;
    mem_we_next = 1'b0;
    mem_wdata_next = mem_wdata_reg;
    skip_next = 1'b0;
    done_next = 1'b0;
    state_next = state_reg;
    unique case (state_reg)
      SEQ_RUN: begin
        if (issue) begin
          done_next = 1'b1;
          unique case (i_req.op)
            OP_ROT_LEFT_TO_ACC: acc_next = {i_req.mem[6:0], i_req.mem[7]}; // see RULE_01
            OP_ROT_LEFT_CARRY_MEM: begin
              mem_we_next = 1'b1;
              mem_wdata_next = {i_req.mem[6:0], flags_reg.carry}; // see RULE_02
              flags_next.carry = i_req.mem[7];
            end
            OP_ROT_LEFT_CARRY_TO_ACC: begin
              acc_next = {i_req.mem[6:0], flags_reg.carry}; // see RULE_03
              flags_next.carry = i_req.mem[7];
            end
            OP_ROT_RIGHT_MEM: begin
              mem_we_next = 1'b1;
              mem_wdata_next = {i_req.mem[0], i_req.mem[7:1]}; // see RULE_04
            end
            OP_ROT_RIGHT_TO_ACC: acc_next = {i_req.mem[0], i_req.mem[7:1]}; // see RULE_05
            OP_ROT_RIGHT_CY_MEM: begin
              mem_we_next = 1'b1;
              mem_wdata_next = {flags_reg.carry, i_req.mem[7:1]}; // see RULE_06
              flags_next.carry = i_req.mem[0];
            end
            OP_ROT_RIGHT_CY_TO_ACC: begin
              acc_next = {flags_reg.carry, i_req.mem[7:1]}; // see RULE_07
              flags_next.carry = i_req.mem[0];
            end
            OP_SUB_BORROW_ACC, OP_SUB_BORROW_ACC_IMM, OP_MINUS_ACC, OP_MINUS_ACC_IMM,
            OP_SUB_BORROW_MEM, OP_MINUS_MEM: begin
              if ((i_req.op == OP_SUB_BORROW_MEM) || (i_req.op == OP_MINUS_MEM)) begin
                mem_we_next = 1'b1; // see RULE_10 see RULE_13
                mem_wdata_next = sub_diff;
              end else begin
                acc_next = sub_diff; // see RULE_08 see RULE_09 see RULE_12 see RULE_14
              end
              flags_next.twos_complement_range_flag = sub_range;
              flags_next.zero = (sub_diff == 8'h00); // see RULE_24
              flags_next.auxiliary_carry = sub_aux;
              flags_next.carry = sub_cy; // see RULE_11
              // sign of the true 9-bit result
              flags_next.signed_carry = sub_range ^ sub_diff[7];
              // on borrow ops chained zero also needs the zero flag left by the previous op
              flags_next.chained_zero_flag = use_borrow ?
                ((sub_diff == 8'h00) && flags_reg.zero) : (sub_diff == 8'h00);
            end
            OP_DEC_SKIP_MEM: begin
              mem_we_next = 1'b1;
              mem_wdata_next = dec_val; // see RULE_15
              skip_next = (dec_val == 8'h00);
            end
            OP_DEC_SKIP_ACC: begin
              acc_next = dec_val; // see RULE_16
              skip_next = (dec_val == 8'h00);
            end
            OP_INC_SKIP_MEM: begin
              mem_we_next = 1'b1;
              mem_wdata_next = inc_val; // see RULE_17
              skip_next = (inc_val == 8'h00);
            end
            OP_INC_SKIP_ACC: begin
              acc_next = inc_val; // see RULE_18
              skip_next = (inc_val == 8'h00);
            end
            OP_SKIP_NZ_BYTE: skip_next = (i_req.mem != 8'h00); // see RULE_19
            OP_SKIP_NZ_BIT: skip_next = |(i_req.mem & bit_mask(i_req.bit_sel)); // see RULE_19
            OP_SET_BYTE: begin
              mem_we_next = 1'b1;
              mem_wdata_next = `MEM_ALL_ONES; // see RULE_21
            end
            OP_SET_BIT: begin
              mem_we_next = 1'b1;
              mem_wdata_next = i_req.mem | bit_mask(i_req.bit_sel); // see RULE_21
            end
            OP_SWAP_MEM: begin
              mem_we_next = 1'b1;
              mem_wdata_next = {i_req.mem[3:0], i_req.mem[7:4]}; // see RULE_22
            end
            default: done_next = 1'b0;
          endcase
          // a taken skip holds a second cycle for the dummy slot
          if (skip_next) begin
            state_next = SEQ_DUMMY; // see RULE_20
          end
        end
      end
      SEQ_DUMMY: begin
        state_next = SEQ_RUN; // see RULE_20 see RULE_23
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= `ACC_RESET;
      flags_reg <= `FLAGS_RESET;
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= 8'h00;
      skip_reg <= 1'b0;
      done_reg <= 1'b0;
      state_reg <= SEQ_RUN;
    end else begin
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      mem_we_reg <= mem_we_next;
      mem_wdata_reg <= mem_wdata_next;
      skip_reg <= skip_next;
      done_reg <= done_next;
      state_reg <= state_next;
    end
  end

  assign o_acc = acc_reg;
  assign o_flags = flags_reg;
  assign o_mem_we = mem_we_reg;
  assign o_mem_wdata = mem_wdata_reg;
  assign o_skip = skip_reg;
  assign o_busy = (state_reg == SEQ_DUMMY);
  assign o_done = done_reg;

  a_rot_left_acc: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_01
    issue && i_req.op == OP_ROT_LEFT_TO_ACC |=> o_acc == {$past(i_req.mem[6:0]),
      $past(i_req.mem[7])}
      && o_flags == $past(o_flags) && !o_mem_we) else $error("rotate left to acc wrong");
  a_rot_left_carry: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_02
    issue && i_req.op == OP_ROT_LEFT_CARRY_MEM |=> o_mem_we && o_flags.carry == $past(i_req.mem[7])
      && o_mem_wdata[0] == $past(o_flags.carry)) else $error("rotate left through carry wrong");
  a_rot_right_carry: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_07
    issue && i_req.op == OP_ROT_RIGHT_CY_TO_ACC |=> o_flags.carry == $past(i_req.mem[0])
      && o_acc[7] == $past(o_flags.carry)) else $error("rotate right through carry wrong");
  a_sub_carry: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_11
    issue && i_req.op == OP_MINUS_ACC |=> o_flags.carry == ($past(o_acc) >= $past(i_req.mem)))
    else $error("subtract carry wrong");
  a_sub_zero: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_24
    issue && i_req.op == OP_MINUS_ACC |=> o_flags.zero == (o_acc == 8'h00))
    else $error("subtract zero flag wrong");
  a_skip_two_cyc: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_20
    o_skip |-> o_busy ##1 !o_busy) else $error("skip not two cycles");
  a_dummy_discard: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_23
    o_busy |=> !o_mem_we && !o_done && $stable(o_acc) && $stable(o_flags))
    else $error("skipped instruction took effect");
  a_dec_skip: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_15
    issue && i_req.op == OP_DEC_SKIP_MEM |=> o_skip == (o_mem_wdata == 8'h00) && o_mem_we
      && $stable(o_flags)) else $error("decrement skip wrong");
  a_swap_mem: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_22
    issue && i_req.op == OP_SWAP_MEM |=> o_mem_wdata == {$past(i_req.mem[3:0]),
      $past(i_req.mem[7:4])} && $stable(o_flags)) else $error("swap wrong");
  a_left_carry_acc: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_03
    issue && i_req.op == OP_ROT_LEFT_CARRY_TO_ACC |=> !o_mem_we
      && o_acc == {$past(i_req.mem[6:0]), $past(o_flags.carry)}
      && o_flags.carry == $past(i_req.mem[7])) else $error("rotate left carry to acc wrong");
  a_right_mem: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_04
    issue && i_req.op == OP_ROT_RIGHT_MEM |=> o_mem_we && $stable(o_flags)
      && o_mem_wdata == {$past(i_req.mem[0]), $past(i_req.mem[7:1])})
    else $error("rotate right to memory wrong");
  a_right_acc: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_05
    issue && i_req.op == OP_ROT_RIGHT_TO_ACC |=> !o_mem_we && $stable(o_flags)
      && o_acc == {$past(i_req.mem[0]), $past(i_req.mem[7:1])})
    else $error("rotate right to acc wrong");
  a_right_carry_mem: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_06
    issue && i_req.op == OP_ROT_RIGHT_CY_MEM |=> o_mem_we && o_flags.carry == $past(i_req.mem[0])
      && o_mem_wdata == {$past(o_flags.carry), $past(i_req.mem[7:1])})
    else $error("rotate right through carry to memory wrong");
  a_borrow_acc: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_08
    issue && i_req.op == OP_SUB_BORROW_ACC |=> !o_mem_we
      && o_acc == $past(o_acc) - $past(i_req.mem) - {7'h00, ~$past(o_flags.carry)})
    else $error("subtract with borrow to acc wrong");
  a_borrow_imm: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_09
    issue && i_req.op == OP_SUB_BORROW_ACC_IMM |=> !o_mem_we
      && o_acc == $past(o_acc) - $past(i_req.literal) - {7'h00, ~$past(o_flags.carry)})
    else $error("subtract literal with borrow wrong");
  a_borrow_mem: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_10
    issue && i_req.op == OP_SUB_BORROW_MEM |=> o_mem_we && $stable(o_acc)
      && o_mem_wdata == $past(o_acc) - $past(i_req.mem) - {7'h00, ~$past(o_flags.carry)})
    else $error("subtract with borrow to memory wrong");
  a_minus_mem: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_13
    issue && i_req.op == OP_MINUS_MEM |=> o_mem_we && $stable(o_acc)
      && o_mem_wdata == $past(o_acc) - $past(i_req.mem)) else $error("subtract to memory wrong");
  a_minus_imm: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_14
    issue && i_req.op == OP_MINUS_ACC_IMM |=> o_acc == $past(o_acc) - $past(i_req.literal)
      && o_flags.carry == ($past(o_acc) >= $past(i_req.literal)))
    else $error("subtract literal wrong");
  a_dec_acc: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_16
    issue && i_req.op == OP_DEC_SKIP_ACC |=> !o_mem_we && $stable(o_flags)
      && o_acc == $past(i_req.mem) - 8'h01 && o_skip == (o_acc == 8'h00))
    else $error("decrement skip to acc wrong");
  a_inc_mem: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_17
    issue && i_req.op == OP_INC_SKIP_MEM |=> o_mem_we && $stable(o_flags)
      && o_mem_wdata == $past(i_req.mem) + 8'h01 && o_skip == (o_mem_wdata == 8'h00))
    else $error("increment skip wrong");
  a_inc_acc: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_18
    issue && i_req.op == OP_INC_SKIP_ACC |=> !o_mem_we && $stable(o_flags)
      && o_acc == $past(i_req.mem) + 8'h01 && o_skip == (o_acc == 8'h00))
    else $error("increment skip to acc wrong");
  a_nonzero_byte: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_19
    issue && i_req.op == OP_SKIP_NZ_BYTE |=> !o_mem_we && $stable(o_flags)
      && o_skip == ($past(i_req.mem) != 8'h00)) else $error("skip on non-zero byte wrong");
  a_nonzero_bit: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_19
    issue && i_req.op == OP_SKIP_NZ_BIT |=> !o_mem_we && $stable(o_flags)
      && o_skip == $past(i_req.mem[i_req.bit_sel])) else $error("skip on non-zero bit wrong");
  a_set_byte: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_21
    issue && i_req.op == OP_SET_BYTE |=> o_mem_we && o_mem_wdata == `MEM_ALL_ONES
      && $stable(o_flags)) else $error("set byte wrong");
  a_set_bit: assert property (@(posedge i_sys_clk) disable iff (!rstn) // see RULE_21
    issue && i_req.op == OP_SET_BIT |=> o_mem_we && $stable(o_flags)
      && o_mem_wdata == ($past(i_req.mem) | (8'h01 << $past(i_req.bit_sel))))
    else $error("set bit wrong");
endmodule

// ==== tb_alu_datapath.sv ====
// self-checking bench for the rotate, subtract, set, swap and skip datapath
`timescale 1ns/100ps
module tb_alu_datapath;
  import alu_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_req_valid = 1'b0;
  alu_req_s i_req = '0;
  logic [7:0] o_acc;
  alu_flags_s o_flags;
  logic o_mem_we, o_skip, o_busy, o_done;
  logic [7:0] o_mem_wdata;
  logic [7:0] exp_acc, exp_wd;
  alu_flags_s exp_fl;
  logic exp_we, exp_skip, exp_done;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  alu_datapath alu_datapath_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_acc(o_acc), .o_flags(o_flags),
    .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_skip(o_skip),
    .o_busy(o_busy), .o_done(o_done));

  always #50 i_sys_clk = ~i_sys_clk;

  // whole run is about 200 cycles, so this only trips on a hang
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  task automatic final_report();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] v);
    exp_we = 1'b1;
    exp_wd = v;
  endtask

  task automatic sub(input alu_req_s r);
    logic [7:0] a, b, d;
    logic bin, rng, chain;
    a = exp_acc;
    b = (r.op inside {OP_SUB_BORROW_ACC_IMM, OP_MINUS_ACC_IMM}) ? r.literal : r.mem;
    chain = r.op inside {OP_SUB_BORROW_ACC, OP_SUB_BORROW_ACC_IMM, OP_SUB_BORROW_MEM};
    bin = chain && !exp_fl.carry;
    d = a - b - {7'h00, bin};
    rng = (a[7] != b[7]) && (d[7] != a[7]);
    exp_fl.carry = ({1'b0, a} >= {1'b0, b} + {8'h00, bin});
    exp_fl.auxiliary_carry = ({1'b0, a[3:0]} >= {1'b0, b[3:0]} + {4'h0, bin});
    exp_fl.twos_complement_range_flag = rng;
    exp_fl.signed_carry = rng ^ d[7];
    // chained zero needs the old zero, so it goes first
    exp_fl.chained_zero_flag = (d == 8'h00) && (chain ? exp_fl.zero : 1'b1);
    exp_fl.zero = (d == 8'h00);
    if (r.op inside {OP_SUB_BORROW_MEM, OP_MINUS_MEM}) wr(d);
    else exp_acc = d;
  endtask

  task automatic predict(input alu_req_s r);
    logic [7:0] m;
    logic cin;
    m = r.mem;
    cin = exp_fl.carry;
    exp_we = 1'b0;
    exp_skip = 1'b0;
    exp_done = 1'b1;
    case (r.op)
      OP_ROT_LEFT_TO_ACC: exp_acc = {m[6:0], m[7]};
      OP_ROT_LEFT_CARRY_MEM: wr({m[6:0], cin});
      OP_ROT_LEFT_CARRY_TO_ACC: exp_acc = {m[6:0], cin};
      OP_ROT_RIGHT_MEM: wr({m[0], m[7:1]});
      OP_ROT_RIGHT_TO_ACC: exp_acc = {m[0], m[7:1]};
      OP_ROT_RIGHT_CY_MEM: wr({cin, m[7:1]});
      OP_ROT_RIGHT_CY_TO_ACC: exp_acc = {cin, m[7:1]};
      OP_DEC_SKIP_MEM: wr(m - 8'h01);
      OP_DEC_SKIP_ACC: exp_acc = m - 8'h01;
      OP_INC_SKIP_MEM: wr(m + 8'h01);
      OP_INC_SKIP_ACC: exp_acc = m + 8'h01;
      OP_SKIP_NZ_BYTE: exp_skip = |m;
      OP_SKIP_NZ_BIT: exp_skip = m[r.bit_sel];
      OP_SET_BYTE: wr(8'hff);
      OP_SET_BIT: wr(m | (8'h01 << r.bit_sel));
      OP_SWAP_MEM: wr({m[3:0], m[7:4]});
      OP_SUB_BORROW_ACC, OP_SUB_BORROW_ACC_IMM, OP_SUB_BORROW_MEM: sub(r);
      OP_MINUS_ACC, OP_MINUS_ACC_IMM, OP_MINUS_MEM: sub(r);
      default: exp_done = 1'b0;
    endcase
    if (r.op inside {OP_ROT_LEFT_CARRY_MEM, OP_ROT_LEFT_CARRY_TO_ACC}) exp_fl.carry = m[7];
    if (r.op inside {OP_ROT_RIGHT_CY_MEM, OP_ROT_RIGHT_CY_TO_ACC}) exp_fl.carry = m[0];
    if (r.op inside {OP_DEC_SKIP_MEM, OP_DEC_SKIP_ACC}) exp_skip = (m == 8'h01);
    if (r.op inside {OP_INC_SKIP_MEM, OP_INC_SKIP_ACC}) exp_skip = (m == 8'hff);
  endtask

  // drop presents a set-byte in the dummy slot, which must leave no trace
  task automatic run(input alu_op_e op, input logic [7:0] m, input logic [7:0] lit,
      input logic [2:0] bs, input logic drop);
    alu_req_s r;
    r = '{op: op, mem: m, literal: lit, bit_sel: bs};
    predict(r);
    @(posedge i_sys_clk);
    i_req_valid <= 1'b1;
    i_req <= r;
    @(posedge i_sys_clk);
    i_req_valid <= drop;
    i_req <= '{op: OP_SET_BYTE, mem: 8'h00, literal: 8'h00, bit_sel: 3'h0};
    #1;
    chk({o_acc, o_mem_wdata}, {exp_acc, exp_wd});
    chk({10'h000, o_flags}, {10'h000, exp_fl});
    chk({12'h000, o_mem_we, o_skip, o_done, o_busy},
      {12'h000, exp_we, exp_skip, exp_done, exp_skip});
    @(posedge i_sys_clk);
    i_req_valid <= 1'b0;
    #1;
    chk({12'h000, o_mem_we, o_skip, o_done, o_busy}, 16'h0000);
    chk({o_acc, o_mem_wdata}, {exp_acc, exp_wd});
  endtask

  task automatic do_reset();
    @(posedge i_sys_clk);
    i_rstn <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    exp_acc = 8'h00;
    exp_wd = 8'h00;
    exp_fl = '0;
    chk({o_acc, o_mem_wdata}, 16'h0000);
    chk({6'h00, o_flags, o_mem_we, o_skip, o_done, o_busy}, 16'h0000);
  endtask

  initial begin
    do_reset();
    run(OP_ROT_LEFT_TO_ACC, 8'h81, 8'h00, 3'h0, 1'b0);
    run(OP_ROT_LEFT_CARRY_MEM, 8'h80, 8'h00, 3'h0, 1'b0);
    run(OP_ROT_RIGHT_CY_MEM, 8'h03, 8'h00, 3'h0, 1'b0);
    run(OP_ROT_LEFT_CARRY_TO_ACC, 8'h01, 8'h00, 3'h0, 1'b0);
    run(OP_ROT_RIGHT_MEM, 8'h01, 8'h00, 3'h0, 1'b0);
    run(OP_ROT_RIGHT_TO_ACC, 8'h02, 8'h00, 3'h0, 1'b0);
    run(OP_ROT_RIGHT_CY_MEM, 8'h03, 8'h00, 3'h0, 1'b0);
    run(OP_ROT_LEFT_CARRY_MEM, 8'h81, 8'h00, 3'h0, 1'b0);
    run(OP_ROT_RIGHT_CY_TO_ACC, 8'h00, 8'h00, 3'h0, 1'b0);
    run(OP_MINUS_ACC, 8'h01, 8'h00, 3'h0, 1'b0);
    run(OP_MINUS_ACC_IMM, 8'h00, 8'h7f, 3'h0, 1'b0);
    run(OP_SUB_BORROW_ACC, 8'h00, 8'h00, 3'h0, 1'b0);
    run(OP_SUB_BORROW_ACC_IMM, 8'h00, 8'h01, 3'h0, 1'b0);
    run(OP_SUB_BORROW_ACC, 8'hfe, 8'h00, 3'h0, 1'b0);
    run(OP_SUB_BORROW_MEM, 8'h10, 8'h00, 3'h0, 1'b0);
    run(OP_MINUS_MEM, 8'h50, 8'h00, 3'h0, 1'b0);
    run(OP_DEC_SKIP_MEM, 8'h01, 8'h00, 3'h0, 1'b1);
    run(OP_DEC_SKIP_MEM, 8'h00, 8'h00, 3'h0, 1'b0);
    run(OP_DEC_SKIP_ACC, 8'h01, 8'h00, 3'h0, 1'b1);
    run(OP_DEC_SKIP_ACC, 8'h80, 8'h00, 3'h0, 1'b0);
    run(OP_INC_SKIP_MEM, 8'hff, 8'h00, 3'h0, 1'b1);
    run(OP_INC_SKIP_MEM, 8'h7f, 8'h00, 3'h0, 1'b0);
    run(OP_INC_SKIP_ACC, 8'hff, 8'h00, 3'h0, 1'b1);
    run(OP_INC_SKIP_ACC, 8'hfe, 8'h00, 3'h0, 1'b0);
    run(OP_SKIP_NZ_BYTE, 8'h00, 8'h00, 3'h0, 1'b0);
    run(OP_SKIP_NZ_BYTE, 8'h40, 8'h00, 3'h0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      run(OP_SKIP_NZ_BIT, 8'h01 << i, 8'h00, 3'(i), 1'b1);
      run(OP_SKIP_NZ_BIT, 8'h01 << i, 8'h00, 3'(i + 1), 1'b0);
      run(OP_SET_BIT, 8'h5a, 8'h00, 3'(i), 1'b0);
    end
    run(OP_SET_BYTE, 8'h00, 8'h00, 3'h0, 1'b0);
    run(OP_SWAP_MEM, 8'h3c, 8'h00, 3'h0, 1'b0);
    run(OP_NONE, 8'h55, 8'h55, 3'h0, 1'b0);
    run(alu_op_e'(5'h1f), 8'h55, 8'h55, 3'h0, 1'b0);
    do_reset();
    run(OP_MINUS_ACC, 8'h01, 8'h00, 3'h0, 1'b0);
    final_report();
  end
endmodule
